// [bcr_pkg.sv]
// package: register map, field layout and reset values of the clock and nvm control registers
package bcr_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] BCR_ADDR_SYNC_CLOCK = 8'h33;
  localparam logic [7:0] BCR_ADDR_SPREAD = 8'h34;
  localparam logic [7:0] BCR_ADDR_NVM_CTRL = 8'h3A;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int BCR_SLEW_LSB = 6;
  localparam int BCR_LEVEL_MSB = 5;
  localparam int BCR_SPREAD_BIT = 0;
  localparam int BCR_PAGE1_PROG_BIT = 0;
  localparam int BCR_PAGE2_PROG_BIT = 1;
  localparam int BCR_PAGE1_READ_BIT = 4;
  localparam int BCR_PAGE2_READ_BIT = 5;
  localparam logic [7:0] BCR_NVM_RSVD_MASK = 8'hCC;

  // ---------------------------------------------------------------
  // reset values and level limits
  // ---------------------------------------------------------------
  localparam logic [7:0] BCR_RST_SYNC_CLOCK = 8'h00;
  localparam logic [7:0] BCR_RST_SPREAD = 8'h00;
  localparam logic [7:0] BCR_RST_NVM = 8'h00;
  localparam logic [5:0] BCR_LEVEL_MAX = 6'h39;

  // ---------------------------------------------------------------
  // slew timing: 25 mV per step, step interval in microseconds
  // ---------------------------------------------------------------
  localparam int BCR_CLK_MHZ = 125;
  localparam int BCR_STEP_US_BASE = 10;
  localparam int BCR_STEP_CYC_BASE = BCR_STEP_US_BASE * BCR_CLK_MHZ;
  localparam int BCR_STEP_CNT_W = 14;

endpackage

// [bcr_ctrl_if.sv]
// interface: register fields carried from the register file to the slew unit
`timescale 1ns/10ps
interface bcr_ctrl_if;
  logic [1:0] osc_slew_select;
  logic [5:0] osc_level_code;
  logic [5:0] level_now;
  modport regs (output osc_slew_select, output osc_level_code, input level_now);
  modport slew (input osc_slew_select, input osc_level_code, output level_now);
endinterface

// [bcr_slew.sv]
// module: ramps the oscillator level code toward its target at the selected rate
`timescale 1ns/10ps
module bcr_slew
  import bcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fields
  bcr_ctrl_if.slew ctl
);

  logic [BCR_STEP_CNT_W-1:0] cnt_q, cnt_d;
  logic [BCR_STEP_CNT_W-1:0] limit;
  logic [5:0] target;
  logic [5:0] lvl_q, lvl_d;

  // ---------------------------------------------------------------
  // target saturation and step interval
  // ---------------------------------------------------------------
  // codes above the top level hold at the top level
  assign target = (ctl.osc_level_code > BCR_LEVEL_MAX) ? BCR_LEVEL_MAX : ctl.osc_level_code;
  // interval doubles per code: 10, 20, 40, 80 us
  assign limit = BCR_STEP_CNT_W'(BCR_STEP_CYC_BASE << ctl.osc_slew_select);

  // ---------------------------------------------------------------
  // one 25 mV step per interval
  // ---------------------------------------------------------------
  always_comb
  begin
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    if (lvl_q == target)
      cnt_d = '0;
    else if (cnt_q >= limit - BCR_STEP_CNT_W'(1))
    begin
      cnt_d = '0;
      lvl_d = (lvl_q < target) ? lvl_q + 6'h01 : lvl_q - 6'h01;
    end
    else
      cnt_d = cnt_q + BCR_STEP_CNT_W'(1);
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      lvl_q <= BCR_RST_SYNC_CLOCK[5:0];
    end
    else
    begin
      cnt_q <= cnt_d;
      lvl_q <= lvl_d;
    end
  end

  assign ctl.level_now = lvl_q;

endmodule // bcr_slew

// [bcr_regs.sv]
// module: byte-wide clock and nvm control register bank for the buck converters
`timescale 1ns/10ps
module bcr_regs
  import bcr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register access from the serial slave
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // nvm side
  input wire logic nvm_write_permit_pin,
  input wire logic nvm_page1_read_done,
  input wire logic nvm_page2_read_done,
  output logic nvm_page1_program,
  output logic nvm_page2_program,
  // oscillator control
  output logic [5:0] osc_level,
  output logic [1:0] osc_slew_select,
  output logic spread_spectrum_enable
);

  logic [7:0] clk_ctl_q, clk_ctl_d;
  logic [7:0] spread_q, spread_d;
  logic [7:0] nvm_q, nvm_d;
  logic p1_q, p1_d;
  logic p2_q, p2_d;
  logic [7:0] rdata_q, rdata_d;
  logic [5:0] lvl_q;
  logic wr_nvm;

  bcr_ctrl_if ctl ();

  // ---------------------------------------------------------------
  // slew engine
  // ---------------------------------------------------------------
  assign ctl.osc_slew_select = clk_ctl_q[7:BCR_SLEW_LSB];
  assign ctl.osc_level_code = clk_ctl_q[BCR_LEVEL_MSB:0];

  bcr_slew u_slew (
    .clk(clk),
    .rst_n(rst_n),
    .ctl(ctl)
  );

  // ---------------------------------------------------------------
  // register writes and program pulses
  // ---------------------------------------------------------------
  assign wr_nvm = reg_wr && (reg_addr == BCR_ADDR_NVM_CTRL);

  always_comb
  begin
    clk_ctl_d = clk_ctl_q;
    spread_d = spread_q;
    nvm_d = nvm_q;
    if (reg_wr && reg_addr == BCR_ADDR_SYNC_CLOCK)
      clk_ctl_d = reg_wdata;
    if (reg_wr && reg_addr == BCR_ADDR_SPREAD)
      spread_d = reg_wdata;
    // read flags set by the nvm side; host writes cannot touch them
    if (wr_nvm)
      nvm_d = (nvm_q & ~BCR_NVM_RSVD_MASK) | (reg_wdata & BCR_NVM_RSVD_MASK);
    if (nvm_page1_read_done)
      nvm_d[BCR_PAGE1_READ_BIT] = 1'b1;
    if (nvm_page2_read_done)
      nvm_d[BCR_PAGE2_READ_BIT] = 1'b1;
    // program bits are write-only one-cycle strobes, gated by the permit pin
    p1_d = wr_nvm && reg_wdata[BCR_PAGE1_PROG_BIT] && nvm_write_permit_pin;
    p2_d = wr_nvm && reg_wdata[BCR_PAGE2_PROG_BIT] && nvm_write_permit_pin;
  end

  // ---------------------------------------------------------------
  // read mux: program bits read as zero
  // ---------------------------------------------------------------
  always_comb
  begin
    case (reg_addr)
      BCR_ADDR_SYNC_CLOCK: rdata_d = clk_ctl_q;
      BCR_ADDR_SPREAD: rdata_d = spread_q;
      BCR_ADDR_NVM_CTRL: rdata_d = nvm_q;
      default: rdata_d = rdata_q;
    endcase
  end

  // registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      clk_ctl_q <= BCR_RST_SYNC_CLOCK;
      spread_q <= BCR_RST_SPREAD;
      nvm_q <= BCR_RST_NVM;
      p1_q <= 1'b0;
      p2_q <= 1'b0;
      rdata_q <= 8'h00;
      lvl_q <= 6'h00;
    end
    else
    begin
      clk_ctl_q <= clk_ctl_d;
      spread_q <= spread_d;
      nvm_q <= nvm_d;
      p1_q <= p1_d;
      p2_q <= p2_d;
      rdata_q <= rdata_d;
      lvl_q <= ctl.level_now;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata = rdata_q;
  assign nvm_page1_program = p1_q;
  assign nvm_page2_program = p2_q;
  assign osc_level = lvl_q;
  assign osc_slew_select = clk_ctl_q[7:BCR_SLEW_LSB];
  assign spread_spectrum_enable = spread_q[BCR_SPREAD_BIT];

endmodule // bcr_regs

// [bcr_checker.sv]
// checker: port assertions for the clock and nvm control registers
`timescale 1ns/10ps
module bcr_checker
  import bcr_pkg::*;
(
  // watched ports
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic nvm_write_permit_pin,
  input wire logic nvm_page1_program,
  input wire logic nvm_page2_program,
  input wire logic [5:0] osc_level,
  input wire logic [1:0] osc_slew_select,
  input wire logic spread_spectrum_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // permitted write to the nvm control byte
  sequence nvm_wr;
    reg_wr && reg_addr == BCR_ADDR_NVM_CTRL && nvm_write_permit_pin;
  endsequence
  slew_field_a: assert property (reg_wr && reg_addr == BCR_ADDR_SYNC_CLOCK |=>
    osc_slew_select == $past(reg_wdata[7:6])) else $error("slew field wrong");
  level_cap_a: assert property (osc_level <= BCR_LEVEL_MAX) else $error("level above cap");
  spread_bit_a: assert property (reg_wr && reg_addr == BCR_ADDR_SPREAD |=>
    spread_spectrum_enable == $past(reg_wdata[0])) else $error("spread bit wrong");
  page_one_a: assert property (nvm_wr ##0 reg_wdata[0] |=> nvm_page1_program) else $error("no page one pulse");
  page_two_a: assert property (nvm_wr ##0 reg_wdata[1] |=> nvm_page2_program) else $error("no page two pulse");
  wo_bits_a: assert property (reg_addr == BCR_ADDR_NVM_CTRL |=> reg_rdata[1:0] == 2'h0)
    else $error("program bits read back");
  // a program pulse only ever follows a permitted write with that bit set
  page_one_gate_a: assert property (nvm_page1_program |->
    $past(reg_wr && reg_addr == BCR_ADDR_NVM_CTRL && nvm_write_permit_pin && reg_wdata[0]))
    else $error("page one pulse without permit");
  page_two_gate_a: assert property (nvm_page2_program |->
    $past(reg_wr && reg_addr == BCR_ADDR_NVM_CTRL && nvm_write_permit_pin && reg_wdata[1]))
    else $error("page two pulse without permit");
  // the level moves by one code at a time
  level_step_a: assert property ($changed(osc_level) |->
    osc_level == $past(osc_level) + 6'h01 || osc_level == $past(osc_level) - 6'h01)
    else $error("level jumped");
endmodule // bcr_checker
bind bcr_regs bcr_checker chk_i (.*);

// [bcr_nvm_model.sv]
// partner: nvm side reporting a page read back three cycles after programming
`timescale 1ns/10ps
module bcr_nvm_model
(
  // program pulses in, read done pulses out
  input wire logic clk,
  input wire logic prog1,
  input wire logic prog2,
  output logic done1,
  output logic done2
);
  logic [2:0] p1_q;
  logic [2:0] p2_q;
  // delay line standing in for the page reload time
  always_ff @(posedge clk)
  begin
    p1_q <= {p1_q[1:0], prog1};
    p2_q <= {p2_q[1:0], prog2};
  end
  assign done1 = p1_q[2];
  assign done2 = p2_q[2];
endmodule // bcr_nvm_model

// [test_bcr_regs.sv]
// testbench: random and corner register traffic on the control register bank
`timescale 1ns/10ps
module test_bcr_regs;
  import bcr_pkg::*;
  logic clk = 0, rst_n = 0, reg_wr = 0, permit = 0, d1, d2, p1, p2, sp;
  logic [7:0] reg_addr = 0, reg_wdata = 0, rdata, d, f;
  logic [5:0] lvl;
  logic [1:0] slew;
  logic [7:0] addrs [3] = '{8'h33, 8'h34, 8'h3A};
  int num_errors = 0, checks_done = 0;
  bcr_regs dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(rdata), .nvm_write_permit_pin(permit), .nvm_page1_read_done(d1), .nvm_page2_read_done(d2),
    .nvm_page1_program(p1), .nvm_page2_program(p2), .osc_level(lvl), .osc_slew_select(slew),
    .spread_spectrum_enable(sp));
  bcr_nvm_model nvm (.clk(clk), .prog1(p1), .prog2(p2), .done1(d1), .done2(d2));
  initial forever #4 clk = ~clk;
  // readback of the nvm byte: reserved bits stored, flags sticky
  function automatic logic [7:0] nvm_exp(input logic [7:0] v, input logic [7:0] fl);
    return (v & BCR_NVM_RSVD_MASK) | fl;
  endfunction
  // cycles between two 25 mV steps for a slew code
  function automatic int step_cyc(input logic [1:0] s);
    return BCR_STEP_CYC_BASE << s;
  endfunction
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one bus cycle, launched just after an edge
  task op(input logic w, input logic [7:0] a, input logic [7:0] v);
    reg_wr = w;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1;
  endtask
  // reset for n edges, then every register and field reads zero
  task do_reset(input int n);
    rst_n = 0;
    reg_wr = 0;
    repeat (n) @(posedge clk);
    #1 rst_n = 1;
    foreach (addrs[i])
    begin
      op(0, addrs[i], 8'h00);
      chk(rdata, 8'h00);
    end
    chk({lvl, slew}, 8'h00);
    chk({7'h00, sp}, 8'h00);
  endtask
  task print_verdict;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    void'($urandom(78));
    do_reset(16);
    for (int i = 0; i < 8; i++)
    begin
      d = {i[1:0], 6'($urandom)};
      op(1, 8'h33, d);
      op(0, 8'h33, 8'h00);
      chk(rdata, d);
      chk({6'h00, slew}, {6'h00, d[7:6]});
      d = 8'($urandom);
      op(1, 8'h34, d);
      op(1, 8'h35, ~d);
      op(0, 8'h34, 8'h00);
      chk(rdata, d);
      chk({7'h00, sp}, {7'h00, d[0]});
      // an unmapped address keeps the last read data
      op(0, 8'h35, 8'h00);
      chk(rdata, d);
    end
    f = 8'h00;
    for (int j = 0; j < 8; j++)
    begin
      permit = j[2];
      d = {6'($urandom), j[1:0]};
      op(1, 8'h3A, d);
      chk({6'h00, p2, p1}, permit ? {6'h00, d[1:0]} : 8'h00);
      op(0, 8'h3A, 8'h00);
      chk({6'h00, p2, p1}, 8'h00);
      f = f | (permit ? {2'h0, d[1:0], 4'h0} : 8'h00);
      repeat (5) op(0, 8'h3A, 8'h00);
      chk(rdata, nvm_exp(d, f));
    end
    // mid-run reset clears the flags; then one step at slew code 01
    do_reset(2);
    op(1, 8'h33, 8'h42);
    repeat (step_cyc(2'h1)) op(0, 8'h33, 8'h00);
    chk({2'h0, lvl}, 8'h00);
    op(0, 8'h33, 8'h00);
    chk({2'h0, lvl}, 8'h01);
    op(1, 8'h33, 8'h3F);
    repeat (72000) @(posedge clk);
    #1 chk({2'h0, lvl}, {2'h0, BCR_LEVEL_MAX});
    print_verdict();
  end
  // watchdog well beyond the longest ramp
  initial
  begin
    repeat (90000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule // test_bcr_regs
